// ### fpd_pkg.sv
// package: register map, field layout and divider constants of the pll dividers
package fpd_pkg;

    // ------------------------------------------------------------------
    // register offsets and register reset value
    // ------------------------------------------------------------------
    localparam logic [7:0] FPD_OFS_INPUT_DIV = 8'h02;
    localparam logic [7:0] FPD_OFS_FB_INT    = 8'h03;
    localparam logic [7:0] FPD_OFS_OUT_DIV   = 8'h04;
    localparam logic [7:0] FPD_OFS_FB_FRAC   = 8'h05;
    localparam logic [7:0] FPD_REG_RESET     = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int FPD_M_LSB      = 1;
    localparam int FPD_M_MSB      = 6;
    localparam int FPD_REF_SEL    = 7;
    localparam int FPD_P_LSB      = 1;
    localparam int FPD_P_MSB      = 3;
    localparam int FPD_Q_LSB      = 4;
    localparam int FPD_Q_MSB      = 6;
    localparam int FPD_FRAC_LSB   = 0;
    localparam int FPD_FRAC_MSB   = 4;
    localparam int FPD_DITH_LSB   = 5;
    localparam int FPD_DITH_MSB   = 6;

    // ------------------------------------------------------------------
    // divider limits, tables and modes
    // ------------------------------------------------------------------
    localparam logic [7:0] FPD_N_MIN = 8'h0a;
    localparam logic [7:0] FPD_N_MAX = 8'hfa;
    localparam int         FPD_FRAC_MODULUS = 32;
    localparam logic [3:0] FPD_Q_RATIO [0:7] = '{4'h2, 4'h3, 4'h4, 4'h6,
                                                 4'h8, 4'ha, 4'hc, 4'hd};
    localparam logic [1:0] FPD_DITH_MEDIUM = 2'h0;
    localparam logic [1:0] FPD_DITH_SMALL  = 2'h1;
    localparam logic [1:0] FPD_DITH_LARGE  = 2'h2;
    localparam logic [1:0] FPD_DITH_OFF    = 2'h3;
    localparam logic [7:0] FPD_LFSR_SEED   = 8'h01;

    // ------------------------------------------------------------------
    // clock plan figures
    // ------------------------------------------------------------------
    localparam int FPD_CLK_HZ        = 10_000_000;
    localparam int FPD_DAC_FS_MULT   = 250;
    localparam int FPD_ADC_FS_MULT   = 125;
    localparam int FPD_B_PER_C       = FPD_DAC_FS_MULT / FPD_ADC_FS_MULT;
    localparam int FPD_POINT_A_HZ    = 12_000_000;
    localparam int FPD_POINT_A_ALT   = 11_025_000;
    localparam int FPD_MAX_OUT_HZ    = 30_000_000;

    typedef struct packed {
        logic [7:0] reg_m;
        logic [7:0] reg_n;
        logic [7:0] reg_p;
        logic [7:0] reg_f;
        logic       mclk_d;
        logic       bclk_d;
        logic       vco_d;
        logic [5:0] m_cnt;
        logic [7:0] n_cnt;
        logic [2:0] p_cnt;
        logic [3:0] q_cnt;
        logic [4:0] frac_acc;
        logic [2:0] dith_prev;
        logic [7:0] lfsr;
        logic       c_phase;
        logic       a_tick;
        logic       comp_tick;
        logic       fb_tick;
        logic       b_tick;
        logic       c_tick;
        logic       q_tick;
        logic [7:0] rd_data;
    } fpd_state_t;

endpackage

// ### fpd_dividers.sv
// fractional-n pll reference, feedback, output and q divider logic
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Contract
// - dac clock at point b runs at 250 times its sample rate
// - adc clock at point c runs at 125 times its sample rate
// - input divider field bits 6:1, ratio is field plus one
// - bit 7 picks reference: 0 master clock, 1 bit clock
// - feedback integer clamps below 10 to 10, above 250 to 250
// - output divider field bits 3:1, ratio is field plus one
// - q divider code in bits 6:4 maps to 2,3,4,6,8,10,12,13
// - fraction bits 4:0 add value over 32; zero means integer
// - dither bits 6:5: medium, small, large, off
// - output equals reference times n over m times p
// - clocks up to 30 mhz, fraction error noise-shaped
// - without exact match, act as audio master, source supplies on demand
// - integer q path serves common rates from 12 or 13 mhz clocks
// - every configuration register resets to zero
// - point a expects 12.000 or 11.025 mhz
// ----------------------------------------------------------------------
module fpd_dividers
    import fpd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data,
    input  wire logic       mclk_in,
    input  wire logic       bclk_in,
    input  wire logic       vco_in,
    output logic            point_a_tick,
    output logic            comp_tick,
    output logic            fb_tick,
    output logic            point_b_tick,
    output logic            point_c_tick,
    output logic            q_tick,
    output logic      [6:0] m_ratio,
    output logic      [7:0] n_ratio,
    output logic      [3:0] p_ratio,
    output logic      [3:0] q_ratio,
    output logic      [4:0] feedback_fraction_field,
    output logic      [1:0] dither_mode
);

    // ------------------------------------------------------------------
    // decode of the stored settings
    // ------------------------------------------------------------------
    fpd_state_t       st;
    fpd_state_t       next_st;
    logic             mclk_rise;
    logic             bclk_rise;
    logic             ref_rise;
    logic             vco_rise;
    logic       [2:0] dith;
    logic signed [8:0] fr_sum;
    logic       [3:0] carry;
    logic       [7:0] n_load;
    logic             lfsr_fb;

    assign mclk_rise = mclk_in & ~st.mclk_d;
    assign bclk_rise = bclk_in & ~st.bclk_d;
    assign vco_rise  = vco_in & ~st.vco_d;
    // reference mux ahead of the input divider
    assign ref_rise  = st.reg_m[FPD_REF_SEL] ? bclk_rise : mclk_rise;

    assign m_ratio = {1'b0, st.reg_m[FPD_M_MSB:FPD_M_LSB]} + 7'h01;
    assign p_ratio = {1'b0, st.reg_p[FPD_P_MSB:FPD_P_LSB]} + 4'h1;
    assign q_ratio = FPD_Q_RATIO[st.reg_p[FPD_Q_MSB:FPD_Q_LSB]];
    assign n_ratio = (st.reg_n < FPD_N_MIN) ? FPD_N_MIN :
                     (st.reg_n > FPD_N_MAX) ? FPD_N_MAX : st.reg_n;
    assign feedback_fraction_field = st.reg_f[FPD_FRAC_MSB:FPD_FRAC_LSB];
    assign dither_mode = st.reg_f[FPD_DITH_MSB:FPD_DITH_LSB];

    // ------------------------------------------------------------------
    // sigma-delta modulus control of the feedback divider
    // ------------------------------------------------------------------
    // dither is high-passed (new minus previous) so it adds no mean error
    always_comb begin
        dith = 3'h0;
        if (feedback_fraction_field != 5'h00) begin
            unique case (dither_mode)
                FPD_DITH_MEDIUM: dith = {1'b0, st.lfsr[1:0]};
                FPD_DITH_SMALL:  dith = {2'b00, st.lfsr[0]};
                FPD_DITH_LARGE:  dith = st.lfsr[2:0];
                FPD_DITH_OFF:    dith = 3'h0;
            endcase
        end
    end

    // first-order accumulator over the modulus; carry stretches n, or shortens it by one when the dither difference is negative
    assign fr_sum = $signed({4'h0, st.frac_acc})
                  + $signed({4'h0, feedback_fraction_field})
                  + $signed({6'h00, dith})
                  - $signed({6'h00, st.dith_prev});
    assign carry   = fr_sum[8:5];
    assign n_load  = n_ratio + {{4{carry[3]}}, carry};
    assign lfsr_fb = st.lfsr[7] ^ st.lfsr[5] ^ st.lfsr[4] ^ st.lfsr[3];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.mclk_d    = mclk_in;
        next_st.bclk_d    = bclk_in;
        next_st.vco_d     = vco_in;
        next_st.a_tick    = 1'b0;
        next_st.comp_tick = 1'b0;
        next_st.fb_tick   = 1'b0;
        next_st.b_tick    = 1'b0;
        next_st.c_tick    = 1'b0;
        next_st.q_tick    = 1'b0;

        // register writes: whole byte kept, reserved bits only stored
        if (wr_en) begin
            unique case (addr)
                FPD_OFS_INPUT_DIV: next_st.reg_m = wr_data;
                FPD_OFS_FB_INT:    next_st.reg_n = wr_data;
                FPD_OFS_OUT_DIV:   next_st.reg_p = wr_data;
                FPD_OFS_FB_FRAC:   next_st.reg_f = wr_data;
                default:           next_st.reg_m = st.reg_m;
            endcase
        end

        unique case (addr)
            FPD_OFS_INPUT_DIV: next_st.rd_data = st.reg_m;
            FPD_OFS_FB_INT:    next_st.rd_data = st.reg_n;
            FPD_OFS_OUT_DIV:   next_st.rd_data = st.reg_p;
            FPD_OFS_FB_FRAC:   next_st.rd_data = st.reg_f;
            default:           next_st.rd_data = 8'h00;
        endcase

        // point a: master clock straight to control logic
        next_st.a_tick = mclk_rise;

        // input divider: one comparison pulse per m reference edges
        if (ref_rise) begin
            if (st.m_cnt == 6'h00) begin
                next_st.comp_tick = 1'b1;
                next_st.m_cnt = st.reg_m[FPD_M_MSB:FPD_M_LSB];
            end else begin
                next_st.m_cnt = st.m_cnt - 6'h01;
            end
        end

        // feedback and output dividers count vco edges
        if (vco_rise) begin
            if (st.n_cnt <= 8'h01) begin
                next_st.fb_tick   = 1'b1;
                next_st.n_cnt     = n_load;
                next_st.frac_acc  = fr_sum[4:0];
                next_st.dith_prev = dith;
                next_st.lfsr      = {st.lfsr[6:0], lfsr_fb};
            end else begin
                next_st.n_cnt = st.n_cnt - 8'h01;
            end
            if (st.p_cnt == 3'h0) begin
                // b and c ticks also time the port when it is audio master
                next_st.b_tick  = 1'b1;
                next_st.p_cnt   = st.reg_p[FPD_P_MSB:FPD_P_LSB];
                // point c at half of point b: 250 fs versus 125 fs
                next_st.c_phase = ~st.c_phase;
                next_st.c_tick  = st.c_phase;
            end else begin
                next_st.p_cnt = st.p_cnt - 3'h1;
            end
        end

        // q divider from the master clock, the pll-free integer path
        if (mclk_rise) begin
            if (st.q_cnt == 4'h0) begin
                next_st.q_tick = 1'b1;
                next_st.q_cnt  = q_ratio - 4'h1;
            end else begin
                next_st.q_cnt = st.q_cnt - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            st       <= '0;
            st.reg_m <= FPD_REG_RESET;
            st.reg_n <= FPD_REG_RESET;
            st.reg_p <= FPD_REG_RESET;
            st.reg_f <= FPD_REG_RESET;
            st.lfsr  <= FPD_LFSR_SEED;
            // detectors track the pins, so release makes no false edge
            st.mclk_d <= mclk_in;
            st.bclk_d <= bclk_in;
            st.vco_d  <= vco_in;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data      = st.rd_data;
    assign point_a_tick = st.a_tick;
    assign comp_tick    = st.comp_tick;
    assign fb_tick      = st.fb_tick;
    assign point_b_tick = st.b_tick;
    assign point_c_tick = st.c_tick;
    assign q_tick       = st.q_tick;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_REF_SELECT: assert property (
        @(posedge clk) disable iff (reset)
        comp_tick |-> $past(st.reg_m[FPD_REF_SEL] ? (bclk_in & ~st.bclk_d)
                                                  : (mclk_in & ~st.mclk_d)))
        else $error("comparison pulse not from selected reference");

    AST_M_RELOAD: assert property (
        @(posedge clk) disable iff (reset)
        (ref_rise && st.m_cnt == 6'h00 && !wr_en)
        |=> (comp_tick && st.m_cnt == st.reg_m[6:1]))
        else $error("input divider did not reload field value");

    AST_N_CLAMP: assert property (
        @(posedge clk) disable iff (reset)
        (n_ratio >= 8'h0a && n_ratio <= 8'hfa) &&
        ((st.reg_n < 8'h0b || st.reg_n > 8'hf9) || n_ratio == st.reg_n))
        else $error("feedback integer ratio out of clamp");

    AST_P_RATIO: assert property (
        @(posedge clk) disable iff (reset)
        (vco_rise && st.p_cnt == 3'h0 && !wr_en)
        |=> (point_b_tick && st.p_cnt == $past(st.reg_p[3:1])))
        else $error("output divider did not reload field value");

    AST_Q_RATIO: assert property (
        @(posedge clk) disable iff (reset)
        (mclk_rise && st.q_cnt == 4'h0 && !wr_en)
        |=> (q_tick && st.q_cnt == $past(q_ratio) - 4'h1))
        else $error("q divider reloaded wrong count");

    AST_INTEGER_MODE: assert property (
        @(posedge clk) disable iff (reset)
        (vco_rise && st.n_cnt <= 8'h01 && st.reg_f[4:0] == 5'h00
         && st.dith_prev == 3'h0 && st.frac_acc == 5'h00 && !wr_en)
        |=> (fb_tick && st.n_cnt == n_ratio))
        else $error("zero fraction did not give integer divide");

    AST_DITHER_OFF: assert property (
        @(posedge clk) disable iff (reset)
        (st.reg_f[6:5] == 2'h3 || st.reg_f[4:0] == 5'h00) |-> dith == 3'h0)
        else $error("dither active while disabled");

    AST_POINT_C_HALF: assert property (
        @(posedge clk) disable iff (reset)
        point_c_tick |-> (point_b_tick && !$past(st.c_phase, 1) == 1'b0))
        else $error("point c not at half of point b");

    AST_RESET_ZERO: assert property (
        @(posedge clk)
        reset |=> (st.reg_m == 8'h00 && st.reg_n == 8'h00 &&
                   st.reg_p == 8'h00 && st.reg_f == 8'h00))
        else $error("configuration register not zero after reset");

    AST_WRITE_READ: assert property (
        @(posedge clk) disable iff (reset)
        (wr_en && addr == 8'h03) ##1 (!wr_en && addr == 8'h03)
        |=> rd_data == $past(wr_data, 2))
        else $error("read did not return last written value");

    AST_COMP_PULSE: assert property (
        @(posedge clk) disable iff (reset)
        comp_tick |=> !comp_tick)
        else $error("comparison pulse longer than one cycle");

    AST_B_PULSE: assert property (
        @(posedge clk) disable iff (reset)
        point_b_tick |=> !point_b_tick)
        else $error("point b pulse longer than one cycle");

    AST_N_LOAD_RANGE: assert property (
        @(posedge clk) disable iff (reset)
        (vco_rise && st.n_cnt <= 8'h01 && !wr_en)
        |=> (st.n_cnt + 8'h01 >= n_ratio && st.n_cnt <= n_ratio + 8'h02))
        else $error("feedback count outside one below to two above n");

    AST_NO_DITHER_CARRY: assert property (
        @(posedge clk) disable iff (reset)
        (vco_rise && st.n_cnt <= 8'h01 && st.reg_f[6:5] == 2'h3
         && st.dith_prev == 3'h0 && !wr_en)
        |=> (st.n_cnt == n_ratio || st.n_cnt == n_ratio + 8'h01))
        else $error("undithered fraction stretched n by more than one");

    AST_Q_TOP: assert property (
        @(posedge clk) disable iff (reset)
        st.reg_p[6:4] == 3'h7 |-> q_ratio == 4'hd)
        else $error("top q code does not divide by thirteen");

    AST_RD_UNMAPPED: assert property (
        @(posedge clk) disable iff (reset)
        (addr < 8'h02 || addr > 8'h05) |=> rd_data == 8'h00)
        else $error("unmapped offset did not read zero");

endmodule

// ### fpd_clock_source.sv
// free-running master clock, bit clock and vco level model
`timescale 1ns/10ps
module fpd_clock_source #(
    parameter int MCLK_HALF = 2,
    parameter int BCLK_HALF = 3,
    parameter int VCO_HALF  = 2
) (
    input  wire logic clk,
    output logic      mclk_in,
    output logic      bclk_in,
    output logic      vco_in
);
    // ----------------------------------------------------------------
    // sources
    // ----------------------------------------------------------------
    int cm = 0;
    int cb = 0;
    int cv = 0;
    initial begin
        mclk_in = 1'b0;
        bclk_in = 1'b0;
        vco_in  = 1'b0;
    end
    // half periods of two clk or more, edges closer are never seen
    always @(posedge clk) begin
        cm <= (cm == MCLK_HALF - 1) ? 0 : cm + 1;
        cb <= (cb == BCLK_HALF - 1) ? 0 : cb + 1;
        cv <= (cv == VCO_HALF - 1) ? 0 : cv + 1;
        if (cm == MCLK_HALF - 1)
            mclk_in <= ~mclk_in;
        if (cb == BCLK_HALF - 1)
            bclk_in <= ~bclk_in;
        if (cv == VCO_HALF - 1)
            vco_in <= ~vco_in;
    end
endmodule

// ### testbench.sv
// self-checking bench for the pll divider block and its register port
`timescale 1ns/10ps
module testbench
    import fpd_pkg::*;
;
    logic       clk, reset, wr_en;
    logic [7:0] addr, wr_data, rd_data;
    logic       mclk_in, bclk_in, vco_in;
    logic       point_a_tick, comp_tick, fb_tick;
    logic       point_b_tick, point_c_tick, q_tick;
    logic [6:0] m_ratio;
    logic [7:0] n_ratio;
    logic [3:0] p_ratio, q_ratio;
    logic [4:0] feedback_fraction_field;
    logic [1:0] dither_mode;
    logic [2:0] src_d;
    logic [8:0] ev;
    logic [3:0] q_exp [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'hd};
    logic [7:0] n_in  [6] = '{8'h00, 8'h0a, 8'h0b, 8'hf9, 8'hfa, 8'hff};
    logic [7:0] n_exp [6] = '{8'h0a, 8'h0a, 8'h0b, 8'hf9, 8'hfa, 8'hfa};
    int         cnt [9] = '{default: 0};
    int         base [9];
    int         dlt [9];
    int         num_errors, cmp_count, cycles;

    fpd_dividers uut (.clk, .reset, .wr_en, .addr, .wr_data, .rd_data,
        .mclk_in, .bclk_in, .vco_in, .point_a_tick, .comp_tick, .fb_tick,
        .point_b_tick, .point_c_tick, .q_tick, .m_ratio, .n_ratio,
        .p_ratio, .q_ratio, .feedback_fraction_field, .dither_mode);
    fpd_clock_source src (.clk, .mclk_in, .bclk_in, .vco_in);

    // ----------------------------------------------------------------
    // clock, edge and tick counters, hang guard
    // ----------------------------------------------------------------
    always #50 clk = ~clk;
    assign ev = {q_tick, point_c_tick, point_b_tick, fb_tick, comp_tick,
                 point_a_tick, vco_in & ~src_d[2], bclk_in & ~src_d[1],
                 mclk_in & ~src_d[0]};
    always @(posedge clk) begin
        src_d <= {vco_in, bclk_in, mclk_in};
        for (int i = 0; i < 9; i++)
            if (ev[i] === 1'b1)
                cnt[i] <= cnt[i] + 1;
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(negedge clk);
        check(nm, {8'h00, rd_data}, {8'h00, e});
    endtask
    // settle first: a new ratio only loads at the next counter expiry
    task automatic measure();
        repeat (300) @(negedge clk);
        base = cnt;
        repeat (3000) @(negedge clk);
        foreach (dlt[i])
            dlt[i] = cnt[i] - base[i];
    endtask
    // r2 is twice the ratio; window edges allow two ticks of slack
    task automatic ratio(input string nm, input int tk, input int ed,
                         input int r2);
        int diff;
        diff = tk * r2 - ed * 2;
        check(nm, 16'(diff <= 2 * r2 && diff >= -2 * r2), 16'h0001);
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        wr_en = 1'b0;
        addr = 8'h00;
        wr_data = 8'h00;
        num_errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rchk("m reg", FPD_OFS_INPUT_DIV, 8'h00);
        rchk("n reg", FPD_OFS_FB_INT, 8'h00);
        rchk("p reg", FPD_OFS_OUT_DIV, 8'h00);
        rchk("frac reg", FPD_OFS_FB_FRAC, 8'h00);
        check("n idle", 16'(n_ratio), 16'h000a);
        done("reset");
        wr(FPD_OFS_INPUT_DIV, 8'h7e);
        wr(FPD_OFS_FB_INT, 8'hfa);
        wr(FPD_OFS_OUT_DIV, 8'h7e);
        wr(FPD_OFS_FB_FRAC, 8'h7f);
        wr(8'h06, 8'h55);
        rchk("m back", FPD_OFS_INPUT_DIV, 8'h7e);
        rchk("n back", FPD_OFS_FB_INT, 8'hfa);
        rchk("p back", FPD_OFS_OUT_DIV, 8'h7e);
        rchk("frac back", FPD_OFS_FB_FRAC, 8'h7f);
        rchk("unmapped", 8'h06, 8'h00);
        check("m max", 16'(m_ratio), 16'h0040);
        check("frac max", 16'(feedback_fraction_field), 16'h001f);
        done("readback");
        for (int i = 0; i < 6; i++) begin
            wr(FPD_OFS_FB_INT, n_in[i]);
            check("n clamp", 16'(n_ratio), 16'(n_exp[i]));
        end
        wr(FPD_OFS_FB_INT, 8'h00);
        wr(FPD_OFS_FB_FRAC, 8'h60);
        // a count near 250 left from the clamp sweep runs ~1000 cycles
        repeat (1100) @(negedge clk);
        measure();
        ratio("fb integer", dlt[5], dlt[2], 20);
        for (int d = 0; d < 4; d++) begin
            wr(FPD_OFS_FB_FRAC, {1'b0, 2'(d), 5'h10});
            check("dither", 16'(dither_mode), 16'(d));
            measure();
            ratio("fb fraction", dlt[5], dlt[2], 21);
        end
        done("feedback");
        wr(FPD_OFS_INPUT_DIV, 8'h06);
        measure();
        ratio("comp mclk", dlt[4], dlt[0], 8);
        ratio("point a", dlt[3], dlt[0], 2);
        wr(FPD_OFS_INPUT_DIV, 8'h86);
        measure();
        ratio("comp bclk", dlt[4], dlt[1], 8);
        wr(FPD_OFS_INPUT_DIV, 8'h7e);
        measure();
        ratio("comp m64", dlt[4], dlt[0], 128);
        done("input divider");
        for (int k = 0; k < 8; k++) begin
            wr(FPD_OFS_OUT_DIV, {1'b0, 3'(k), 3'(k), 1'b0});
            check("p ratio", 16'(p_ratio), 16'(k + 1));
            check("q ratio", 16'(q_ratio), 16'(q_exp[k]));
            measure();
            ratio("point b", dlt[6], dlt[2], 2 * (k + 1));
            ratio("point c", dlt[7], dlt[6], 2 * FPD_B_PER_C);
            ratio("q div", dlt[8], dlt[0], 2 * int'(q_exp[k]));
        end
        done("output dividers");
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rchk("p cleared", FPD_OFS_OUT_DIV, 8'h00);
        rchk("m cleared", FPD_OFS_INPUT_DIV, 8'h00);
        check("p idle", 16'(p_ratio), 16'h0001);
        done("second reset");
        give_verdict();
    end
endmodule
